/* File: src/irqpe_pkg.sv */
/*
 * Package of the request-flag and priority-enable block: register indices,
 * reset values, field positions and the priority level encoding.
 * Assumes an APB slave with 32-bit data; byte address is four times an index.
 */
package irqpe_pkg;

    // ************************************************************
    // Register indices (byte address = index * 4)
    // ************************************************************
    localparam logic [29:0] IDX_GROUP0_FLAGS = 30'h00ffe030;
    localparam logic [29:0] IDX_GROUP0_SET = 30'h00ffe031;
    localparam logic [29:0] IDX_GROUP0_ENABLE_HIGH = 30'h00ffe032;
    localparam logic [29:0] IDX_GROUP0_ENABLE_LOW = 30'h00ffe033;
    localparam logic [29:0] IDX_GROUP2_FLAGS = 30'h00ffe038;
    localparam logic [29:0] IDX_GROUP2_SET = 30'h00ffe039;
    localparam logic [29:0] IDX_EVENT_STATUS = 30'h00ffe03c;
    localparam logic [29:0] IDX_EVENT_CLEAR = 30'h00ffe03d;
    localparam logic [29:0] IDX_EVENT_ENABLE = 30'h00ffe03e;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_GROUP0_FLAGS = 8'h00;
    localparam logic [7:0] RST_GROUP0_ENABLE_HIGH = 8'h00;
    localparam logic [7:0] RST_GROUP0_ENABLE_LOW = 8'h00;
    localparam logic [7:0] RST_GROUP2_FLAGS = 8'h00;
    localparam logic [2:0] RST_EVENT_STATUS = 3'h0;
    localparam logic [2:0] RST_EVENT_ENABLE = 3'h0;

    // ************************************************************
    // Field positions
    // ************************************************************
    // Group 2 flags
    localparam int BIT_MOTOR_TIMER = 7;
    localparam int BIT_SECOND_UART_RX = 6;
    localparam int BIT_SECOND_UART_TX = 5;
    localparam int BIT_MOTOR_FAULT = 4;
    localparam int BIT_PORTC_LSB = 0;
    localparam int PORTC_WIDTH = 4;
    // Group 0 flags and enables
    localparam int BIT_TIMER2 = 7;
    localparam int BIT_TIMER1 = 6;
    localparam int BIT_TIMER0 = 5;
    localparam int BIT_FIRST_UART_RX = 4;
    localparam int BIT_FIRST_UART_TX = 3;
    localparam int BIT_TWO_WIRE = 2;
    localparam int BIT_SERIAL_PERIPH = 1;
    localparam int BIT_CONVERTER = 0;
    // Event status, clear and enable
    localparam int EVT_GROUP0_NEW = 0;
    localparam int EVT_GROUP2_NEW = 1;
    localparam int EVT_BAD_ACCESS = 2;
    localparam int EVT_WIDTH = 3;

    // ************************************************************
    // Priority level encoding {high, low}
    // ************************************************************
    typedef enum logic [1:0] {
        IRQPE_LVL_DISABLED = 2'b00,
        IRQPE_LVL_LOW = 2'b01,
        IRQPE_LVL_NOMINAL = 2'b10,
        IRQPE_LVL_HIGH = 2'b11
    } irqpe_level_e;

endpackage

/* File: src/irqpe_top.sv */
/*
 * Request flags of groups 0 and 2, their set registers, the group 0
 * two-bit priority enables and the priority selection toward the CPU.
 * Assumes an APB master on pclk, request inputs synchronous to pclk, and
 * group 2 enable codes supplied by registers outside this block.
 */
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps

//
// Operation
// - A presented group 2 source request sets its flag bit to one.
// - With global enable high, pending enabled flags are forwarded to the CPU.
// - With global enable low nothing is forwarded; flags stay readable.
// - Writing ones to the flag register clears those flags; zeros leave them.
// - Group 2 bit 7 is the motor PWM timer request.
// - Group 2 bit 6 is second UART receive, bit 5 second UART transmit.
// - Group 2 bit 4 is the PWM fault request.
// - Group 2 bits 3..0 are port C pin or DMA channel requests.
// - Enable high/low pair: 00 off, 01 level 1, 10 level 2, 11 level 3.
// - Group 0 high enables: timer2..timer0, uart rx, uart tx, two-wire, SPI, converter.
// - Group 0 low enables use the same bit order as the high enables.
// - Group 0 flags: timer2..timer0, uart rx, uart tx, two-wire, SPI, converter.
module irqpe_top
    import irqpe_pkg::*;
#(
    parameter int GROUP_WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic motor_timer_req,
    input wire logic second_uart_rx_req,
    input wire logic second_uart_tx_req,
    input wire logic motor_fault_req,
    input wire logic [3:0] portc_or_channel_req,
    input wire logic [7:0] group0_source_req,
    input wire logic [7:0] group2_enable_high_in,
    input wire logic [7:0] group2_enable_low_in,
    input wire logic global_irq_enable,
    output logic cpu_irq_valid,
    output logic [1:0] cpu_irq_level,
    output logic cpu_irq_group2,
    output logic [2:0] cpu_irq_bit,
    output logic irq
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [1:0] level_of(input logic hi, input logic lo);
        level_of = {hi, lo};
    endfunction

    function automatic logic addr_is(input logic [31:0] a, input logic [29:0] idx);
        addr_is = (a == {idx, 2'b00});
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0] group0_request_flags_reg;
    logic [7:0] group0_request_flags_next;
    logic [7:0] group0_enable_high_reg;
    logic [7:0] group0_enable_low_reg;
    logic [7:0] group2_request_flags_reg;
    logic [7:0] group2_request_flags_next;
    logic [EVT_WIDTH-1:0] event_status_reg;
    logic [EVT_WIDTH-1:0] event_status_next;
    logic [EVT_WIDTH-1:0] event_enable_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic cpu_irq_valid_reg;
    logic [1:0] cpu_irq_level_reg;
    logic cpu_irq_group2_reg;
    logic [2:0] cpu_irq_bit_reg;

    logic access;
    logic setup;
    logic wr;
    logic mapped;
    logic rd_mapped;
    logic [7:0] wbyte;
    logic [7:0] group2_source;
    logic [7:0] g0_clear;
    logic [7:0] g0_set;
    logic [7:0] g2_clear;
    logic [7:0] g2_set;
    logic [EVT_WIDTH-1:0] evt_clear;
    logic [EVT_WIDTH-1:0] evt_raise;

    // ************************************************************
    // APB decode
    // ************************************************************
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    // Lane 0 only; upper lanes of an 8-bit register have nothing to hold
    assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;

    // Write-only registers read as zero but are still mapped
    assign rd_mapped = addr_is(paddr, IDX_GROUP0_FLAGS)
        || addr_is(paddr, IDX_GROUP0_ENABLE_HIGH)
        || addr_is(paddr, IDX_GROUP0_ENABLE_LOW)
        || addr_is(paddr, IDX_GROUP2_FLAGS)
        || addr_is(paddr, IDX_EVENT_STATUS)
        || addr_is(paddr, IDX_EVENT_ENABLE);
    assign mapped = rd_mapped
        || addr_is(paddr, IDX_GROUP0_SET)
        || addr_is(paddr, IDX_GROUP2_SET)
        || addr_is(paddr, IDX_EVENT_CLEAR);

    // Zero wait states: every access finishes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = prdata_reg;

    // ************************************************************
    // Read data, captured in the setup cycle
    // ************************************************************
    always_comb begin
        prdata_next = prdata_reg;
        if (setup && !pwrite) begin
            prdata_next = 32'h0000_0000;
            if (addr_is(paddr, IDX_GROUP0_FLAGS)) begin
                prdata_next[7:0] = group0_request_flags_reg;
            end else if (addr_is(paddr, IDX_GROUP0_ENABLE_HIGH)) begin
                prdata_next[7:0] = group0_enable_high_reg;
            end else if (addr_is(paddr, IDX_GROUP0_ENABLE_LOW)) begin
                prdata_next[7:0] = group0_enable_low_reg;
            end else if (addr_is(paddr, IDX_GROUP2_FLAGS)) begin
                prdata_next[7:0] = group2_request_flags_reg;
            end else if (addr_is(paddr, IDX_EVENT_STATUS)) begin
                prdata_next[EVT_WIDTH-1:0] = event_status_reg;
            end else if (addr_is(paddr, IDX_EVENT_ENABLE)) begin
                prdata_next[EVT_WIDTH-1:0] = event_enable_reg;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    // ************************************************************
    // Request flags
    // ************************************************************
    // Group 2 source order, bit 7 down to bit 0
    always_comb begin
        group2_source = 8'h00;
        group2_source[BIT_MOTOR_TIMER] = motor_timer_req;
        group2_source[BIT_SECOND_UART_RX] = second_uart_rx_req;
        group2_source[BIT_SECOND_UART_TX] = second_uart_tx_req;
        group2_source[BIT_MOTOR_FAULT] = motor_fault_req;
        group2_source[BIT_PORTC_LSB +: PORTC_WIDTH] = portc_or_channel_req;
    end

    assign g0_clear = (wr && addr_is(paddr, IDX_GROUP0_FLAGS)) ? wbyte : 8'h00;
    assign g0_set = (wr && addr_is(paddr, IDX_GROUP0_SET)) ? wbyte : 8'h00;
    assign g2_clear = (wr && addr_is(paddr, IDX_GROUP2_FLAGS)) ? wbyte : 8'h00;
    assign g2_set = (wr && addr_is(paddr, IDX_GROUP2_SET)) ? wbyte : 8'h00;

    // Set beats clear so a request landing on the clearing write survives
    assign group0_request_flags_next =
        (group0_request_flags_reg & ~g0_clear) | g0_set | group0_source_req;
    assign group2_request_flags_next =
        (group2_request_flags_reg & ~g2_clear)
        | g2_set
        | group2_source;

    // Flags are set regardless of enable codes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            group0_request_flags_reg <= RST_GROUP0_FLAGS;
            group2_request_flags_reg <= RST_GROUP2_FLAGS;
        end else begin
            group0_request_flags_reg <= group0_request_flags_next;
            group2_request_flags_reg <= group2_request_flags_next;
        end
    end

    // ************************************************************
    // Group 0 priority enables
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            group0_enable_high_reg <= RST_GROUP0_ENABLE_HIGH;
            group0_enable_low_reg <= RST_GROUP0_ENABLE_LOW;
        end else begin
            if (wr && pstrb[0] && addr_is(paddr, IDX_GROUP0_ENABLE_HIGH)) begin
                group0_enable_high_reg <= pwdata[7:0];
            end
            if (wr && pstrb[0] && addr_is(paddr, IDX_GROUP0_ENABLE_LOW)) begin
                group0_enable_low_reg <= pwdata[7:0];
            end
        end
    end

    // ************************************************************
    // Priority selection toward the CPU
    // ************************************************************
    // Strict compare keeps the first found on a tie: group 0 before group 2,
    // higher bit before lower bit.
    logic sel_valid;
    logic [1:0] sel_level;
    logic sel_group2;
    logic [2:0] sel_bit;
    logic [1:0] lvl0;
    logic [1:0] lvl2;

    always_comb begin
        sel_valid = 1'b0;
        sel_level = IRQPE_LVL_DISABLED;
        sel_group2 = 1'b0;
        sel_bit = 3'd0;
        lvl0 = IRQPE_LVL_DISABLED;
        lvl2 = IRQPE_LVL_DISABLED;
        for (int i = GROUP_WIDTH - 1; i >= 0; i--) begin
            lvl0 = level_of(group0_enable_high_reg[i], group0_enable_low_reg[i]);
            // A disabled code never competes
            if (group0_request_flags_reg[i] && lvl0 != IRQPE_LVL_DISABLED
                && (!sel_valid || lvl0 > sel_level)) begin
                sel_valid = 1'b1;
                sel_level = lvl0;
                sel_group2 = 1'b0;
                sel_bit = 3'(i);
            end
        end
        for (int i = GROUP_WIDTH - 1; i >= 0; i--) begin
            lvl2 = level_of(group2_enable_high_in[i], group2_enable_low_in[i]);
            if (group2_request_flags_reg[i] && lvl2 != IRQPE_LVL_DISABLED
                && (!sel_valid || lvl2 > sel_level)) begin
                sel_valid = 1'b1;
                sel_level = lvl2;
                sel_group2 = 1'b1;
                sel_bit = 3'(i);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_irq_valid_reg <= 1'b0;
            cpu_irq_level_reg <= IRQPE_LVL_DISABLED;
            cpu_irq_group2_reg <= 1'b0;
            cpu_irq_bit_reg <= 3'd0;
        end else if (global_irq_enable && sel_valid) begin
            cpu_irq_valid_reg <= 1'b1;
            cpu_irq_level_reg <= sel_level;
            cpu_irq_group2_reg <= sel_group2;
            cpu_irq_bit_reg <= sel_bit;
        end else begin
            // Polled operation: the CPU reads the flags itself
            cpu_irq_valid_reg <= 1'b0;
            cpu_irq_level_reg <= IRQPE_LVL_DISABLED;
            cpu_irq_group2_reg <= 1'b0;
            cpu_irq_bit_reg <= 3'd0;
        end
    end

    assign cpu_irq_valid = cpu_irq_valid_reg;
    assign cpu_irq_level = cpu_irq_level_reg;
    assign cpu_irq_group2 = cpu_irq_group2_reg;
    assign cpu_irq_bit = cpu_irq_bit_reg;

    // ************************************************************
    // Event status, clear, enable and interrupt line
    // ************************************************************
    always_comb begin
        evt_raise = '0;
        evt_raise[EVT_GROUP0_NEW] = |(group0_request_flags_next & ~group0_request_flags_reg);
        evt_raise[EVT_GROUP2_NEW] = |(group2_request_flags_next & ~group2_request_flags_reg);
        evt_raise[EVT_BAD_ACCESS] = pslverr;
    end

    assign evt_clear = (wr && addr_is(paddr, IDX_EVENT_CLEAR))
        ? wbyte[EVT_WIDTH-1:0] : '0;
    assign event_status_next = (event_status_reg & ~evt_clear) | evt_raise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_status_reg <= RST_EVENT_STATUS;
        end else begin
            event_status_reg <= event_status_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_enable_reg <= RST_EVENT_ENABLE;
        end else if (wr && pstrb[0] && addr_is(paddr, IDX_EVENT_ENABLE)) begin
            event_enable_reg <= pwdata[EVT_WIDTH-1:0];
        end
    end

    assign irq = |(event_status_reg & event_enable_reg);

endmodule // irqpe_top

/* File: verif/irqpe_checker.sv */
/*
 * Port checker of the request-flag and priority-enable block.
 * Assumes it is bound to irqpe_top and that everything runs on pclk.
 */
`timescale 1ns/100ps

// ************************************************************
// Port checker
// ************************************************************
module irqpe_checker
    import irqpe_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic motor_timer_req,
    input wire logic [7:0] group2_enable_high_in,
    input wire logic [7:0] group2_enable_low_in,
    input wire logic global_irq_enable,
    input wire logic cpu_irq_valid,
    input wire logic [1:0] cpu_irq_level,
    input wire logic cpu_irq_group2,
    input wire logic [2:0] cpu_irq_bit
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Enable codes as the design saw them one edge ago
    logic [7:0] en_high_reg;
    logic [7:0] en_low_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_high_reg <= 8'h00;
            en_low_reg <= 8'h00;
        end else begin
            en_high_reg <= group2_enable_high_in;
            en_low_reg <= group2_enable_low_in;
        end
    end

    sequence s_hold;
        group2_enable_high_in[7] && group2_enable_low_in[7] && global_irq_enable;
    endsequence
    sequence s_hi_req;
        motor_timer_req && s_hold;
    endsequence

    property p_ready;
        pready == 1'b1;
    endproperty
    property p_err_access;
        pslverr |-> psel && penable;
    endproperty
    property p_err_read0;
        psel && penable && pslverr |-> prdata == 32'h0;
    endproperty
    property p_mapped_ok;
        psel && penable && paddr[31:2] == IDX_GROUP2_FLAGS |-> !pslverr;
    endproperty
    property p_gie;
        cpu_irq_valid |-> $past(global_irq_enable);
    endproperty
    property p_level;
        cpu_irq_valid == (cpu_irq_level != 2'b00);
    endproperty
    property p_code;
        cpu_irq_valid && cpu_irq_group2
            |-> {en_high_reg[cpu_irq_bit], en_low_reg[cpu_irq_bit]} == cpu_irq_level;
    endproperty
    property p_top;
        s_hi_req ##1 s_hold [*2] |-> cpu_irq_valid && cpu_irq_level == 2'b11;
    endproperty

    a_ready: assert property (p_ready) else $error("pready low");
    a_err_access: assert property (p_err_access) else $error("pslverr outside access");
    a_err_read0: assert property (p_err_read0) else $error("refused read not zero");
    a_mapped_ok: assert property (p_mapped_ok) else $error("flag access refused");
    a_gie: assert property (p_gie) else $error("request without global enable");
    a_level: assert property (p_level) else $error("level and valid disagree");
    a_code: assert property (p_code) else $error("level not the enable code");
    a_top: assert property (p_top) else $error("highest request not shown");
endmodule // irqpe_checker

bind irqpe_top irqpe_checker u_irqpe_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_timer_req(motor_timer_req), .group2_enable_high_in(group2_enable_high_in),
    .group2_enable_low_in(group2_enable_low_in), .global_irq_enable(global_irq_enable),
    .cpu_irq_valid(cpu_irq_valid), .cpu_irq_level(cpu_irq_level),
    .cpu_irq_group2(cpu_irq_group2), .cpu_irq_bit(cpu_irq_bit));

/* File: verif/irqpe_cpu_model.sv */
/*
 * CPU core model: takes each vectored request that the block presents.
 * Assumes the request outputs are registered on pclk.
 */
`timescale 1ns/100ps

module irqpe_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cpu_irq_valid,
    input wire logic [1:0] cpu_irq_level,
    input wire logic cpu_irq_group2,
    input wire logic [2:0] cpu_irq_bit,
    output logic [5:0] taken_vec,
    output logic [7:0] taken_count
);
    // Polled mode never reaches here; the bench reads the flags instead
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken_vec <= 6'h00;
            taken_count <= 8'h00;
        end else if (cpu_irq_valid) begin
            taken_vec <= {cpu_irq_level, cpu_irq_group2, cpu_irq_bit};
            taken_count <= taken_count + 8'h01;
        end
    end
endmodule // irqpe_cpu_model

/* File: verif/test_irq_request_and_priority_enable.sv */
/*
 * Self-checking bench of the request-flag and priority-enable block.
 * Assumes an APB slave with no wait states and one clock.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end

module test_irq_request_and_priority_enable;
    import irqpe_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic gie = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, cpu_irq_valid, cpu_irq_group2, irq, errv;
    logic [1:0] cpu_irq_level;
    logic [2:0] cpu_irq_bit;
    logic [7:0] src2 = 8'h0, src0 = 8'h0, en2h = 8'h0, en2l = 8'h0, cnt, v, m;
    logic [5:0] taken;
    int fail_count = 0;
    int samples_checked = 0;
    localparam logic [29:0] RIDX [5] = '{IDX_GROUP0_ENABLE_HIGH, IDX_GROUP0_ENABLE_LOW,
        IDX_GROUP2_FLAGS, IDX_GROUP2_SET, IDX_GROUP0_FLAGS};

    always #4 pclk = ~pclk;

    irqpe_top u_irqpe_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .motor_timer_req(src2[7]),
        .second_uart_rx_req(src2[6]), .second_uart_tx_req(src2[5]),
        .motor_fault_req(src2[4]), .portc_or_channel_req(src2[3:0]),
        .group0_source_req(src0), .group2_enable_high_in(en2h), .group2_enable_low_in(en2l),
        .global_irq_enable(gie), .cpu_irq_valid(cpu_irq_valid), .cpu_irq_level(cpu_irq_level),
        .cpu_irq_group2(cpu_irq_group2), .cpu_irq_bit(cpu_irq_bit), .irq(irq));
    irqpe_cpu_model u_irqpe_cpu_model (.pclk(pclk), .presetn(presetn),
        .cpu_irq_valid(cpu_irq_valid), .cpu_irq_level(cpu_irq_level),
        .cpu_irq_group2(cpu_irq_group2), .cpu_irq_bit(cpu_irq_bit), .taken_vec(taken),
        .taken_count(cnt));

    // ************************************************************
    // Expectations
    // ************************************************************
    function automatic logic [7:0] w1c(input logic [7:0] f, input logic [7:0] c);
        return f & ~c;
    endfunction
    // Group 0 bit 3 at code c against group 2 bit 5 at nominal; ties go to group 0
    function automatic logic [5:0] pick(input logic [1:0] c);
        return (c >= 2'b10) ? {c, 1'b0, 3'd3} : {2'b10, 1'b1, 3'd5};
    endfunction

    // ************************************************************
    // Drivers
    // ************************************************************
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [29:0] idx, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            fail_count++;
            stop_test();
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input logic [7:0] s2, input logic [7:0] s0);
        @(posedge pclk);
        src2 <= s2;
        src0 <= s0;
        @(posedge pclk);
        src2 <= 8'h0;
        src0 <= 8'h0;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        void'($urandom(29498));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (RIDX[k]) begin
            apb(1'b0, RIDX[k], 32'h0);
            `CHK("reset_value", 32'h0, rdv)
        end
        for (int k = 0; k < 4; k++) begin
            v = 8'($urandom);
            apb(1'b1, IDX_GROUP0_ENABLE_HIGH, {24'h0, v});
            apb(1'b1, IDX_GROUP0_ENABLE_LOW, {24'h0, ~v});
            apb(1'b0, IDX_GROUP0_ENABLE_HIGH, 32'h0);
            `CHK("enable_high", {24'h0, v}, rdv)
            apb(1'b0, IDX_GROUP0_ENABLE_LOW, 32'h0);
            `CHK("enable_low", {24'h0, ~v}, rdv)
        end
        // Polled mode: one bit at a time, same bit in group 2 and group 0 together, flags read back
        for (int b = 0; b < 8; b++) begin
            pulse(8'h01 << b, 8'h01 << b);
            apb(1'b0, IDX_GROUP2_FLAGS, 32'h0);
            `CHK("group2_flag", 32'h1 << b, rdv)
            apb(1'b0, IDX_GROUP0_FLAGS, 32'h0);
            `CHK("group0_flag", 32'h1 << b, rdv)
            apb(1'b1, IDX_GROUP2_FLAGS, 32'hff);
            apb(1'b1, IDX_GROUP0_FLAGS, 32'hff);
        end
        `CHK("polled_taken", 8'h00, cnt)
        for (int k = 0; k < 6; k++) begin
            v = (k == 0) ? 8'h00 : 8'($urandom);
            m = (k == 1) ? 8'h00 : 8'($urandom);
            apb(1'b1, IDX_GROUP2_SET, {24'h0, v});
            apb(1'b1, IDX_GROUP2_FLAGS, {24'h0, m});
            apb(1'b0, IDX_GROUP2_FLAGS, 32'h0);
            `CHK("set_clear", {24'h0, w1c(v, m)}, rdv)
            apb(1'b1, IDX_GROUP2_FLAGS, 32'hff);
        end
        // Vectored mode: every code of one group 0 source against a nominal one
        gie <= 1'b1;
        en2h <= 8'h20;
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, IDX_GROUP0_ENABLE_HIGH, {28'h0, c[1], 3'h0});
            apb(1'b1, IDX_GROUP0_ENABLE_LOW, {28'h0, c[0], 3'h0});
            apb(1'b1, IDX_GROUP0_SET, 32'h08);
            apb(1'b1, IDX_GROUP2_SET, 32'h20);
            repeat (3) @(posedge pclk);
            `CHK("presented", pick(2'(c)), taken)
            apb(1'b1, IDX_GROUP2_FLAGS, 32'h20);
            repeat (3) @(posedge pclk);
            `CHK("disabled_held", c != 0, cpu_irq_valid)
            apb(1'b1, IDX_GROUP0_FLAGS, 32'h08);
        end
        en2h <= 8'h80;
        en2l <= 8'h80;
        pulse(8'h80, 8'h00);
        repeat (3) @(posedge pclk);
        `CHK("motor_high", {2'b11, 1'b1, 3'd7}, taken)
        gie <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK("gie_off", 1'b0, cpu_irq_valid)
        // Event interrupt: raise, mask, clear
        apb(1'b1, IDX_EVENT_CLEAR, 32'h7);
        apb(1'b1, IDX_EVENT_ENABLE, 32'h4);
        `CHK("irq_idle", 1'b0, irq)
        apb(1'b0, 30'h0000_0010, 32'h0);
        `CHK("bad_err", 1'b1, errv)
        `CHK("bad_read", 32'h0, rdv)
        repeat (2) @(posedge pclk);
        `CHK("irq_raised", 1'b1, irq)
        apb(1'b1, IDX_EVENT_ENABLE, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK("irq_masked", 1'b0, irq)
        apb(1'b1, IDX_EVENT_ENABLE, 32'h4);
        repeat (2) @(posedge pclk);
        `CHK("irq_unmasked", 1'b1, irq)
        apb(1'b1, IDX_EVENT_CLEAR, 32'h4);
        repeat (2) @(posedge pclk);
        `CHK("irq_cleared", 1'b0, irq)
        stop_test();
    end
endmodule // test_irq_request_and_priority_enable
